// ==== rtl/drst_pkg.sv ====
// Package of constants and types for the display reset filter sequencer
package drst_pkg;

	// ------------------------------------------------------------
	// Clock and timing (times in microseconds)
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 40;
	localparam int unsigned REJECT_US = 5;
	localparam int unsigned ACCEPT_US = 9;
	localparam int unsigned MIN_LOW_US = 10;
	localparam int unsigned REL_SLEEP_US = 5000;
	localparam int unsigned REL_AWAKE_US = 120000;
	localparam int unsigned BLANK_MAX_US = 120000;

	localparam int unsigned REJECT_CYC = REJECT_US * CLK_MHZ;
	localparam int unsigned ACCEPT_CYC = ACCEPT_US * CLK_MHZ;
	localparam int unsigned MIN_LOW_CYC = MIN_LOW_US * CLK_MHZ;
	localparam int unsigned REL_SLEEP_CYC = REL_SLEEP_US * CLK_MHZ;
	localparam int unsigned REL_AWAKE_CYC = REL_AWAKE_US * CLK_MHZ;
	localparam int unsigned BLANK_MAX_CYC = BLANK_MAX_US * CLK_MHZ;

	// ------------------------------------------------------------
	// Counter widths
	// ------------------------------------------------------------
	localparam int unsigned FILT_W = 9;
	localparam int unsigned CNT_W = 23;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DRST_RUN,
		DRST_HELD,
		DRST_RELEASE
	} drst_mode_t;

	typedef struct packed {
		logic core_reset;
		logic blank;
		logic nvm_load_req;
		logic release_done;
		logic nvm_timeout;
	} drst_status_t;

	typedef struct packed {
		drst_mode_t mode;
		logic [FILT_W-1:0] low_cnt;
		logic [FILT_W-1:0] high_cnt;
		logic [CNT_W-1:0] rel_cnt;
		logic [CNT_W-1:0] blank_cnt;
		logic awake;
		logic load_done;
		drst_status_t sts;
	} drst_state_t;

	typedef struct packed {
		logic meta;
		logic stable;
	} drst_sync_t;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam drst_status_t DRST_STS_RST = '{core_reset: 1'b1, blank: 1'b1,
		nvm_load_req: 1'b0, release_done: 1'b0, nvm_timeout: 1'b0};
	localparam drst_state_t DRST_STATE_RST = '{mode: DRST_HELD, low_cnt: '0,
		high_cnt: '0, rel_cnt: '0, blank_cnt: '0, awake: 1'b0, load_done: 1'b0,
		sts: DRST_STS_RST};
	localparam drst_sync_t DRST_SYNC_RST = '{meta: 1'b1, stable: 1'b1};

endpackage : drst_pkg

// ==== rtl/drst_seq.sv ====
// Display reset glitch filter and reset-release sequencer
// ------------------------------------------------------------
// Overview of operation
// - Reject lows under 5us, reset beyond 9us
// - Reload settings from nonvolatile store on release
// - Blank during reset, then adopt reset defaults
// - Short high spikes never end a reset
// - Release completes within 5ms asleep, 120ms awake
// ------------------------------------------------------------
`timescale 1ns/1ps
module drst_seq
	import drst_pkg::*;
#(
	parameter int unsigned REJECT_CYCLES = REJECT_CYC,
	parameter int unsigned ACCEPT_CYCLES = ACCEPT_CYC,
	parameter int unsigned REL_SLEEP_CYCLES = REL_SLEEP_CYC,
	parameter int unsigned REL_AWAKE_CYCLES = REL_AWAKE_CYC,
	parameter int unsigned BLANK_CYCLES = BLANK_MAX_CYC
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Reset pin from the host
	input wire logic reset_input_low_n_in,
	// Device state and nonvolatile store handshake
	input wire logic sleep_out_in,
	input wire logic nvm_done_in,
	// Sequencer status
	output drst_status_t status_out
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (REJECT_CYCLES < 2 || REJECT_CYCLES >= ACCEPT_CYCLES
		|| ACCEPT_CYCLES >= (1 << FILT_W))
	begin : g_bad_filter
		$error("drst_seq: filter thresholds out of range");
	end
	if (REL_SLEEP_CYCLES <= REJECT_CYCLES || REL_AWAKE_CYCLES < REL_SLEEP_CYCLES
		|| REL_AWAKE_CYCLES >= (1 << CNT_W) || BLANK_CYCLES < 1
		|| BLANK_CYCLES > REL_AWAKE_CYCLES)
	begin : g_bad_window
		$error("drst_seq: release window counts out of range");
	end

	localparam logic [FILT_W-1:0] REJ_M1 = FILT_W'(REJECT_CYCLES - 1);
	localparam logic [FILT_W-1:0] REJ_F = FILT_W'(REJECT_CYCLES);
	localparam logic [FILT_W-1:0] ACC_M1 = FILT_W'(ACCEPT_CYCLES - 1);
	localparam logic [FILT_W-1:0] ACC_F = FILT_W'(ACCEPT_CYCLES);
	localparam logic [CNT_W-1:0] REJ_W = CNT_W'(REJECT_CYCLES);
	localparam logic [CNT_W-1:0] SLEEP_M1 = CNT_W'(REL_SLEEP_CYCLES - 1);
	localparam logic [CNT_W-1:0] AWAKE_M1 = CNT_W'(REL_AWAKE_CYCLES - 1);
	localparam logic [CNT_W-1:0] BLANK_W = CNT_W'(BLANK_CYCLES);

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	logic pin_sync;
	logic pin_low;

	drst_sync2 u_sync (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.async_in(reset_input_low_n_in),
		.sync_out(pin_sync)
	);

	assign pin_low = ~pin_sync;

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	drst_state_t state_r;
	drst_state_t state_nxt;
	logic low_valid;
	logic high_valid;
	logic [CNT_W-1:0] limit_m1;
	logic blank_ok;
	logic loaded;

	always_comb
	begin
		state_nxt = state_r;
		// Saturating counters measure how long the pin has sat at each level
		if (pin_low)
		begin
			state_nxt.high_cnt = '0;
			if (state_r.low_cnt != ACC_F)
				state_nxt.low_cnt = state_r.low_cnt + 1'b1;
		end
		else
		begin
			state_nxt.low_cnt = '0;
			if (state_r.high_cnt != REJ_F)
				state_nxt.high_cnt = state_r.high_cnt + 1'b1;
		end
		low_valid = pin_low && (state_r.low_cnt >= REJ_M1);
		high_valid = !pin_low && (state_r.high_cnt >= REJ_M1);
		limit_m1 = state_r.awake ? AWAKE_M1 : SLEEP_M1;
		blank_ok = !state_r.awake || (state_r.blank_cnt >= BLANK_W);
		loaded = state_r.load_done || nvm_done_in;
		if (state_r.awake && state_r.blank_cnt != BLANK_W)
			state_nxt.blank_cnt = state_r.blank_cnt + 1'b1;
		case (state_r.mode)
			DRST_RUN:
			begin
				if (low_valid)
				begin
					// A pulse past the rejection width starts the reset
					state_nxt.mode = DRST_HELD;
					state_nxt.awake = sleep_out_in;
					state_nxt.blank_cnt = '0;
					state_nxt.sts.blank = 1'b1;
					state_nxt.sts.release_done = 1'b0;
					state_nxt.sts.nvm_timeout = 1'b0;
				end
			end
			DRST_HELD:
			begin
				if (pin_low && state_r.low_cnt == ACC_M1)
					state_nxt.sts.core_reset = 1'b1;
				if (high_valid)
				begin
					// Release counted from the pin edge, not from the filter's verdict
					state_nxt.mode = DRST_RELEASE;
					state_nxt.rel_cnt = REJ_W;
					state_nxt.load_done = 1'b0;
					state_nxt.sts.core_reset = 1'b1;
					state_nxt.sts.nvm_load_req = 1'b1;
				end
			end
			DRST_RELEASE:
			begin
				state_nxt.sts.core_reset = 1'b0;
				state_nxt.rel_cnt = state_r.rel_cnt + 1'b1;
				if (nvm_done_in)
				begin
					state_nxt.load_done = 1'b1;
					state_nxt.sts.nvm_load_req = 1'b0;
				end
				if (low_valid)
				begin
					// A fresh valid pulse restarts the reset, keeping the wake state and blank count
					state_nxt.mode = DRST_HELD;
					state_nxt.awake = state_r.awake;
					state_nxt.sts.blank = 1'b1;
					state_nxt.sts.nvm_load_req = 1'b0;
				end
				else if ((loaded && blank_ok) || state_r.rel_cnt >= limit_m1)
				begin
					// Window forced shut so the host's fixed waits always hold
					state_nxt.mode = DRST_RUN;
					state_nxt.awake = 1'b0;
					state_nxt.sts.blank = 1'b0;
					state_nxt.sts.nvm_load_req = 1'b0;
					state_nxt.sts.nvm_timeout = !loaded;
					state_nxt.sts.release_done = 1'b1;
				end
			end
			default:
			begin
				state_nxt = DRST_STATE_RST;
			end
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			state_r <= DRST_STATE_RST;
		else
			state_r <= state_nxt;
	end

	assign status_out = state_r.sts;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	property p_reject_short;
		(REJECT_CYCLES > 3 && state_r.mode == DRST_RUN && !pin_low) ##1 pin_low [*3]
			##1 !pin_low
			|=> state_r.mode == DRST_RUN;
	endproperty
	a_reject_short: assert property (p_reject_short)
		else $error("short low pulse was taken as a reset");

	property p_full_reset;
		(state_r.mode == DRST_HELD && pin_low && state_r.low_cnt == ACC_M1)
			|=> state_r.sts.core_reset && state_r.sts.blank;
	endproperty
	a_full_reset: assert property (p_full_reset)
		else $error("long low pulse did not reset the core");

	property p_load_on_release;
		$rose(state_r.mode == DRST_RELEASE)
			|-> state_r.sts.nvm_load_req && state_r.rel_cnt == REJ_W;
	endproperty
	a_load_on_release: assert property (p_load_on_release)
		else $error("release did not request the settings load");

	property p_load_ends;
		(state_r.mode == DRST_RELEASE && nvm_done_in) |=> !state_r.sts.nvm_load_req;
	endproperty
	a_load_ends: assert property (p_load_ends)
		else $error("load request stayed up after completion");

	property p_blank_held;
		state_r.mode != DRST_RUN |-> state_r.sts.blank && !state_r.sts.release_done;
	endproperty
	a_blank_held: assert property (p_blank_held)
		else $error("display not blank during reset");

	property p_defaults_once;
		$rose(state_r.mode == DRST_RELEASE) |-> state_r.sts.core_reset
			##1 (!state_r.sts.core_reset || state_r.mode != DRST_RELEASE);
	endproperty
	a_defaults_once: assert property (p_defaults_once)
		else $error("core reset not a single defaults pulse on release");

	property p_spike;
		(REJECT_CYCLES > 2 && state_r.mode == DRST_HELD && pin_low) ##1 !pin_low [*2]
			##1 pin_low
			|-> state_r.mode == DRST_HELD;
	endproperty
	a_spike: assert property (p_spike)
		else $error("high spike ended the reset");

	property p_window;
		state_r.mode == DRST_RELEASE |-> state_r.rel_cnt <= limit_m1;
	endproperty
	a_window: assert property (p_window)
		else $error("release window overran its limit");

	property p_done;
		(state_r.mode == DRST_RELEASE && state_r.rel_cnt >= limit_m1 && !low_valid)
			|=> state_r.mode == DRST_RUN && state_r.sts.release_done
			&& !state_r.sts.blank;
	endproperty
	a_done: assert property (p_done)
		else $error("release did not complete at the limit");

	property p_count;
		(pin_low && state_r.low_cnt < ACC_F)
			|=> state_r.low_cnt == $past(state_r.low_cnt) + 1'b1;
	endproperty
	a_count: assert property (p_count)
		else $error("low time counter failed to advance");

endmodule : drst_seq

// ==== rtl/drst_sync2.sv ====
// Two flip-flop synchroniser for the reset pin
`timescale 1ns/1ps
module drst_sync2
	import drst_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Asynchronous level and its synchronised copy
	input wire logic async_in,
	output logic sync_out
);

	drst_sync_t state_r;
	drst_sync_t state_nxt;

	always_comb
	begin
		state_nxt.meta = async_in;
		state_nxt.stable = state_r.meta;
	end

	// Idle level is high so a chip reset does not fake a pin low pulse
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			state_r <= DRST_SYNC_RST;
		else
			state_r <= state_nxt;
	end

	assign sync_out = state_r.stable;

endmodule : drst_sync2

// ==== tb/drst_host_model.sv ====
// Host model that drives the display reset pin
`timescale 1ns/1ps
module drst_host_model
	import drst_pkg::*;
#(
	parameter int unsigned CMD_WAIT = 200,
	parameter int unsigned WAKE_WAIT = 800
)
(
	// Clock
	input wire logic clk_in,
	// Reset pin, active low
	output logic reset_input_low_n_out
);
	int unsigned since_rise = 0;
	initial reset_input_low_n_out = 1'b1;
	always @(posedge clk_in)
		since_rise <= reset_input_low_n_out ? since_rise + 1 : 0;
	// --------------------------------------------------------
	// Low pulse of n clock cycles, moved off the sampling edge
	// --------------------------------------------------------
	task automatic pulse(input int unsigned n);
		@(negedge clk_in);
		reset_input_low_n_out = 1'b0;
		repeat (n) @(negedge clk_in);
		reset_input_low_n_out = 1'b1;
	endtask : pulse
	// Commands wait for the short window, the wake command for the long one
	task automatic hold_off(input bit wake);
		while (since_rise < (wake ? WAKE_WAIT : CMD_WAIT))
			@(posedge clk_in);
	endtask : hold_off
endmodule : drst_host_model

// ==== tb/test_drst_seq.sv ====
// Testbench for the display reset filter sequencer
`timescale 1ns/1ps
module test_drst_seq
	import drst_pkg::*;
;
	localparam int REJ = 4;
	localparam int ACC = 8;
	localparam int RSL = 200;
	localparam int RAW = 800;
	localparam int BLK = 300;
	localparam int CR = 4;
	localparam int LR = 2;
	localparam int RD = 1;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic pin_n;
	logic sleep_out_in = 1'b0;
	logic nvm_done_in = 1'b0;
	drst_status_t st;
	int err_total = 0;
	int samples_checked = 0;
	int n;
	initial
	begin
		forever #12.5 clk_in = ~clk_in;
	end
	drst_host_model host (.clk_in(clk_in), .reset_input_low_n_out(pin_n));
	drst_seq #(.REJECT_CYCLES(REJ), .ACCEPT_CYCLES(ACC), .REL_SLEEP_CYCLES(RSL),
		.REL_AWAKE_CYCLES(RAW), .BLANK_CYCLES(BLK)) dut (.clk_in(clk_in),
		.reset_in(reset_in), .reset_input_low_n_in(pin_n), .sleep_out_in(sleep_out_in),
		.nvm_done_in(nvm_done_in), .status_out(st));
	// --------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	// Cycles until a status bit reads v; running out of bound ends the run
	task automatic wait_bit(input int idx, input logic v, input int bound);
		n = 0;
		while (st[idx] !== v)
		begin
			@(posedge clk_in);
			#1;
			n++;
			if (n > bound)
			begin
				err_total++;
				$display("mismatch status bit %0d expected %0h seen timeout", idx, v);
				give_verdict();
			end
		end
	endtask : wait_bit
	task automatic nvm_ack();
		wait_bit(LR, 1'b1, REJ + 6);
		@(negedge clk_in);
		nvm_done_in = 1'b1;
		@(negedge clk_in);
		nvm_done_in = 1'b0;
	endtask : nvm_ack
	// --------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------
	task automatic s_reject();
		host.pulse(REJ - 1);
		repeat (20) @(negedge clk_in);
		check("blank short low", st.blank, 1'b0);
		check("core_reset short low", st.core_reset, 1'b0);
	endtask : s_reject
	task automatic s_full();
		host.pulse(20);
		check("blank held", st.blank, 1'b1);
		check("core_reset long low", st.core_reset, 1'b1);
		nvm_ack();
		wait_bit(RD, 1'b1, RSL);
		check("blank after release", st.blank, 1'b0);
		check("timeout flag", st.nvm_timeout, 1'b0);
		check("core_reset after release", st.core_reset, 1'b0);
	endtask : s_full
	task automatic s_mid();
		host.pulse(REJ + 2);
		repeat (3) @(negedge clk_in);
		check("blank mid low", st.blank, 1'b1);
		check("core_reset mid low", st.core_reset, 1'b0);
		wait_bit(CR, 1'b1, REJ + 6);
		check("load with mid reset", st.nvm_load_req, 1'b1);
		nvm_ack();
		wait_bit(RD, 1'b1, RSL);
	endtask : s_mid
	task automatic s_spike();
		host.pulse(20);
		repeat (2) @(negedge clk_in);
		host.pulse(10);
		check("load during spike", st.nvm_load_req, 1'b0);
		check("done during spike", st.release_done, 1'b0);
		check("core_reset over spike", st.core_reset, 1'b1);
		nvm_ack();
		wait_bit(RD, 1'b1, RSL);
	endtask : s_spike
	task automatic s_awake();
		@(negedge clk_in);
		sleep_out_in = 1'b1;
		host.pulse(20);
		nvm_ack();
		wait_bit(RD, 1'b1, RAW);
		check("awake blank span", n >= BLK - 40 && n <= BLK, 1'b1);
		@(negedge clk_in);
		sleep_out_in = 1'b0;
		host.hold_off(1'b1);
	endtask : s_awake
	task automatic s_timeout();
		host.pulse(20);
		wait_bit(LR, 1'b1, REJ + 6);
		wait_bit(RD, 1'b1, RSL);
		check("sleep window length", n >= RSL - 2 * REJ && n <= RSL, 1'b1);
		check("timeout flag", st.nvm_timeout, 1'b1);
		host.hold_off(1'b0);
	endtask : s_timeout
	// A valid low while the window runs starts the reset over
	task automatic s_restart();
		host.pulse(20);
		wait_bit(LR, 1'b1, REJ + 6);
		host.pulse(20);
		check("load dropped on restart", st.nvm_load_req, 1'b0);
		check("blank on restart", st.blank, 1'b1);
		check("core_reset on restart", st.core_reset, 1'b1);
		nvm_ack();
		wait_bit(RD, 1'b1, RSL);
	endtask : s_restart
	task automatic s_chip_reset();
		@(negedge clk_in);
		reset_in = 1'b1;
		repeat (3) @(negedge clk_in);
		check("status in mid reset", st, DRST_STS_RST);
		reset_in = 1'b0;
		nvm_ack();
		wait_bit(RD, 1'b1, RSL);
		check("blank after chip reset", st.blank, 1'b0);
	endtask : s_chip_reset
	// --------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------
	initial
	begin
		repeat (5) @(negedge clk_in);
		check("status in reset", st, DRST_STS_RST);
		reset_in = 1'b0;
		nvm_ack();
		wait_bit(RD, 1'b1, RSL);
		s_reject();
		s_full();
		s_mid();
		s_spike();
		s_awake();
		s_timeout();
		s_restart();
		s_chip_reset();
		give_verdict();
	end
endmodule : test_drst_seq
